// ---- dv/sgcb_asserts.sv ----
// Purpose: port checks for the global control bit bank
// Assumes: one clock, synchronous active-low reset
// Notes:   register state is hidden, so checks tie outputs to port causes
`timescale 1ns/10ps
`default_nettype none
module sgcb_asserts
(
   input wire       clk_sys_i,
   input wire       rst_n_i,
   input wire [7:0] reg_addr_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire       reg_rvalid_o,
   input wire       frm_valid_i,
   input wire       frm_drop_o,
   input wire       frm_drop_valid_o,
   input wire [4:0] an_tx_pause_i,
   input wire [4:0] an_rx_pause_i,
   input wire [4:0] tx_pause_en_o,
   input wire [4:0] rx_pause_en_o,
   input wire       age_tick_o,
   input wire       age_flush_all_o,
   input wire       age_fast_busy_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read not answered");
   property p_rd_idle; !reg_rvalid_o |-> reg_rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero when idle");
   property p_unmapped;
      reg_rd_i && reg_addr_i != 8'h02 && reg_addr_i != 8'h03
         |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_zero_hi;
      reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o[7:3] == 5'h00;
   endproperty
   a_zero_hi: assert property (p_zero_hi)
      else $error("upper bits of zero register not zero");
   property p_verdict; frm_valid_i |=> frm_drop_valid_o; endproperty
   a_verdict: assert property (p_verdict)
      else $error("frame verdict missing");
   // A port may only send or honour pause when negotiation granted it
   property p_tx_sub;
      (tx_pause_en_o & ~$past(an_tx_pause_i)) == 5'h00;
   endproperty
   a_tx_sub: assert property (p_tx_sub)
      else $error("tx pause without negotiation");
   property p_rx_sub;
      (rx_pause_en_o & ~$past(an_rx_pause_i)) == 5'h00;
   endproperty
   a_rx_sub: assert property (p_rx_sub)
      else $error("rx pause without negotiation");
   property p_flush;
      age_flush_all_o |-> age_tick_o && $past(age_fast_busy_o);
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush outside a fast cycle");
   // Bound suits the shortened fast period used in simulation
   property p_fast_end; $rose(age_fast_busy_o) |-> ##[1:64] age_flush_all_o;
   endproperty
   a_fast_end: assert property (p_fast_end)
      else $error("fast cycle did not finish");
   c_flush: cover property (age_flush_all_o);
   c_drop: cover property (frm_drop_valid_o && frm_drop_o);
   c_read: cover property (reg_rvalid_o);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: directed bench for the global control bit bank
// Assumes: aging periods shortened by parameter
// Notes:   each scenario task drives the ports and judges the result
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk_sys_i = 1'b0, rst_n_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o;
   logic        strap_fc_dis_i = 1'b1, strap_age_en_i = 1'b1;
   logic        strap_aggr_bkoff_i = 1'b1, frm_valid_i = 1'b0;
   logic [4:0]  link_up_i = 5'h1F, an_tx_pause_i = 5'h1B;
   logic [4:0]  an_rx_pause_i = 5'h16, tx_pause_en_o, rx_pause_en_o;
   logic [15:0] frm_type_len_i = 16'h0000, frm_payload_len_i = 16'h0000;
   logic [47:0] frm_da_i = 48'h000000000000;
   logic        frm_is_fc_i = 1'b0, frm_err_i = 1'b0, frm_drop_o;
   logic        frm_drop_valid_o, buf_share_o, aggr_bkoff_o, age_tick_o;
   logic        age_flush_all_o, age_fast_busy_o;
   int          bad_count = 0, n_checks = 0;
   sgcb_global_ctrl #(.NORM_AGE_CYC(40'd200), .FAST_AGE_CYC(40'd20)) dut_u
      (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
       .reg_rdata_o, .reg_rvalid_o, .strap_fc_dis_i, .strap_age_en_i,
       .strap_aggr_bkoff_i, .link_up_i, .an_tx_pause_i, .an_rx_pause_i,
       .frm_valid_i, .frm_type_len_i, .frm_da_i, .frm_is_fc_i, .frm_err_i,
       .frm_payload_len_i, .frm_drop_o, .frm_drop_valid_o, .buf_share_o,
       .tx_pause_en_o, .rx_pause_en_o, .aggr_bkoff_o, .age_tick_o,
       .age_flush_all_o, .age_fast_busy_o);
   initial
   begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk("rdata", {8'h00, reg_rdata_o}, {8'h00, exp});
   endtask
   task automatic frm(input logic [15:0] tl, input logic [47:0] da,
                      input logic fc, er, input logic [15:0] pl, ex);
      @(posedge clk_sys_i);
      frm_valid_i <= 1'b1;
      frm_type_len_i <= tl;
      frm_da_i <= da;
      frm_is_fc_i <= fc;
      frm_err_i <= er;
      frm_payload_len_i <= pl;
      @(posedge clk_sys_i);
      frm_valid_i <= 1'b0;
      #1;
      chk("drop", {15'h0000, frm_drop_o}, ex);
   endtask
   task automatic ticks(input int n, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge clk_sys_i);
         #1;
         c += (age_tick_o === 1'b1);
      end
   endtask
   task automatic t_reset;
      rd(8'h03, 8'h35);
      rd(8'h02, 8'h04);
      chk("share", {15'h0000, buf_share_o}, 16'h0001);
      chk("bkoff", {15'h0000, aggr_bkoff_o}, 16'h0001);
      chk("txp", {11'h000, tx_pause_en_o}, 16'h0000);
      chk("rxp", {11'h000, rx_pause_en_o}, 16'h0000);
   endtask
   task automatic t_pause;
      wr(8'h03, 8'h20);
      chk("bkoff", {15'h0000, aggr_bkoff_o}, 16'h0000);
      chk("txp", {11'h000, tx_pause_en_o}, 16'h0000);
      chk("rxp", {11'h000, rx_pause_en_o}, 16'h0016);
      wr(8'h03, 8'h10);
      chk("txp", {11'h000, tx_pause_en_o}, 16'h001B);
      chk("rxp", {11'h000, rx_pause_en_o}, 16'h0000);
      rd(8'h03, 8'h10);
   endtask
   task automatic t_drop;
      wr(8'h02, 8'h02);
      chk("share", {15'h0000, buf_share_o}, 16'h0000);
      frm(16'h8808, 48'h000000000001, 1'b0, 1'b0, 16'h0040, 1'b1);
      frm(16'h0800, 48'h0180C2000001, 1'b0, 1'b0, 16'h0040, 1'b1);
      frm(16'h0800, 48'h000000000001, 1'b1, 1'b0, 16'h0040, 1'b0);
      wr(8'h02, 8'hF8);
      rd(8'h02, 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h00);
      frm(16'h0800, 48'h000000000001, 1'b1, 1'b0, 16'h0040, 1'b1);
      frm(16'h8808, 48'h0180C2000001, 1'b0, 1'b0, 16'h0040, 1'b0);
   endtask
   task automatic t_len;
      wr(8'h03, 8'h08);
      frm(16'h0040, 48'h000000000001, 1'b0, 1'b0, 16'h0041, 1'b1);
      frm(16'h0040, 48'h000000000001, 1'b0, 1'b0, 16'h0040, 1'b0);
      frm(16'h05DC, 48'h000000000001, 1'b0, 1'b0, 16'h0041, 1'b0);
      frm(16'h0800, 48'h000000000001, 1'b0, 1'b1, 16'h0040, 1'b1);
      wr(8'h03, 8'h88);
      frm(16'h0800, 48'h000000000001, 1'b0, 1'b1, 16'h0040, 1'b0);
   endtask
   task automatic t_age;
      int c;
      int i;
      wr(8'h03, 8'h00);
      wr(8'h02, 8'h01);
      link_up_i <= 5'h1B;
      for (i = 0; i < 100 && age_flush_all_o !== 1'b1; i++)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      chk("flush", {14'h0000, age_flush_all_o, age_tick_o}, 16'h0003);
      link_up_i <= 5'h1F;
      ticks(250, c);
      chk("off", 16'(c), 16'h0000);
      chk("busy", {15'h0000, age_fast_busy_o}, 16'h0000);
      wr(8'h03, 8'h04);
      ticks(450, c);
      chk("norm", 16'(c), 16'h0002);
      wr(8'h03, 8'h06);
      ticks(100, c);
      chk("fast", 16'(c > 3), 16'h0001);
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      t_reset();
      t_pause();
      t_drop();
      t_len();
      t_age();
      tally_and_finish();
   end
   // Whole run needs about 900 cycles
   initial
   begin
      repeat (6000) @(posedge clk_sys_i);
      bad_count++;
      tally_and_finish();
   end
endmodule
bind sgcb_global_ctrl sgcb_asserts chk_u
   (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .frm_valid_i, .frm_drop_o, .frm_drop_valid_o, .an_tx_pause_i,
    .an_rx_pause_i, .tx_pause_en_o, .rx_pause_en_o, .age_tick_o,
    .age_flush_all_o, .age_fast_busy_o);
`default_nettype wire

// ---- hdl/sgcb_age_timer.v ----
// Purpose: address-table aging tick generator
// Assumes: fast and normal periods given in clock cycles
// Notes:   a fast cycle runs one fast period then falls back to what age_en_i and fast_mode_i select
`timescale 1ns/10ps
`default_nettype none
module sgcb_age_timer
#(
   parameter [39:0] NORM_CYC = 40'd12000000000,
   parameter [39:0] FAST_CYC = 40'd31999
)
(
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        age_en_i,
   input  wire        fast_mode_i,
   input  wire        fast_trig_i,
   output reg         age_tick_o,
   output reg         flush_all_o,
   output reg         fast_busy_o
);
   reg [39:0] cnt_r;
   wire       fast_sel = fast_mode_i | fast_busy_o;
   wire [39:0] lim = fast_sel ? FAST_CYC : NORM_CYC;

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r       <= 40'h0000000000;
         age_tick_o  <= 1'b0;
         flush_all_o <= 1'b0;
         fast_busy_o <= 1'b0;
      end
      else
      begin
         age_tick_o  <= 1'b0;
         flush_all_o <= 1'b0;
         if (fast_trig_i)
         begin
            // Restart so the flush lands one fast period after unplug
            cnt_r       <= 40'h0000000000;
            fast_busy_o <= 1'b1;
         end
         else if (!age_en_i && !fast_busy_o)
            cnt_r <= 40'h0000000000;
         else if (cnt_r >= lim)
         begin
            cnt_r       <= 40'h0000000000;
            age_tick_o  <= 1'b1;
            flush_all_o <= fast_busy_o;
            fast_busy_o <= 1'b0;
         end
         else
            cnt_r <= cnt_r + 40'h0000000001;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/sgcb_consts.vh ----
// Purpose: constants for the switch global control bit bank
// Assumes: 40 MHz system clock, 8-bit register data
// Notes:   offsets are register indices on the management port
`ifndef SGCB_CONSTS_VH
`define SGCB_CONSTS_VH
`define SGCB_OFS_CTRL_ZERO   8'h02
`define SGCB_OFS_CTRL_ONE    8'h03
`define SGCB_CTRL_ZERO_RST   3'h4
`define SGCB_CTRL_ONE_RST    8'h00
`define SGCB_C0_LINK_AGE     0
`define SGCB_C0_DROP_SEL     1
`define SGCB_C0_BUF_SHARE    2
`define SGCB_C1_AGGR_BKOFF   0
`define SGCB_C1_FAST_AGE     1
`define SGCB_C1_AGE_EN       2
`define SGCB_C1_LEN_CHK      3
`define SGCB_C1_RX_FC_DIS    4
`define SGCB_C1_TX_FC_DIS    5
`define SGCB_C1_PASS_ALL     7
`define SGCB_FAST_AGE_US     800
`define SGCB_CLK_MHZ         40
`define SGCB_FAST_AGE_CYC    ((`SGCB_FAST_AGE_US * `SGCB_CLK_MHZ) - 1)
`define SGCB_NORM_AGE_S      300
`define SGCB_NORM_AGE_JIT_S  75
// 300 s at 40 MHz; a sized literal since 32-bit macro math would overflow
`define SGCB_NORM_AGE_CYC    40'h02CB417800
`define SGCB_ETYPE_PAUSE     16'h8808
`define SGCB_DA_PAUSE        48'h0180C2000001
`define SGCB_LEN_MAX         16'h05DC
`define SGCB_NUM_PORTS       5
`endif

// ---- hdl/sgcb_global_ctrl.v ----
// Purpose: global control bits of a five-port switch and their effects
// Assumes: register port from the serial management decoder, same clock
// Notes:   strap pins are synchronised and captured after reset release
//
// Function
// - Buffer share 1 lets a port borrow idle pool; 0 caps at one fifth
// - Drop select 1 drops type 0x8808 or pause multicast address frames
// - Drop select 0 drops frames that qualify as flow control
// - Link loss with link-change age set starts fast aging under 800 us
// - After the fast cycle, aging returns to the period set by fast age enable, or stops if aging enable is 0
// - Link-change fast aging flushes every learned address, all ports
// - Pass-all forwards every frame not dropped for flow control, errored ones too, for debugging
// - Tx pause disable 1 blocks pause transmit; 0 follows negotiation
// - Rx pause disable 1 ignores pause frames; 0 follows negotiation
// - Both pause disables reset from one strap, written independently
// - Length check drops mismatched frames whose length is below 1500, when drop select and pass-all are 0
// - Aging enable switches aging; reset value from a pulled-up strap
// - Fast age enable runs aging at the 800 us rate
// - Aggressive backoff for half duplex; reset value from a strap
`timescale 1ns/10ps
`default_nettype none
`include "sgcb_consts.vh"
module sgcb_global_ctrl
#(
   parameter [39:0] NORM_AGE_CYC = `SGCB_NORM_AGE_CYC,
   parameter [39:0] FAST_AGE_CYC = `SGCB_FAST_AGE_CYC
)
(
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire [7:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   output reg         reg_rvalid_o,
   input  wire        strap_fc_dis_i,
   input  wire        strap_age_en_i,
   input  wire        strap_aggr_bkoff_i,
   input  wire [4:0]  link_up_i,
   input  wire [4:0]  an_tx_pause_i,
   input  wire [4:0]  an_rx_pause_i,
   input  wire        frm_valid_i,
   input  wire [15:0] frm_type_len_i,
   input  wire [47:0] frm_da_i,
   input  wire        frm_is_fc_i,
   input  wire        frm_err_i,
   input  wire [15:0] frm_payload_len_i,
   output reg         frm_drop_o,
   output reg         frm_drop_valid_o,
   output reg         buf_share_o,
   output reg  [4:0]  tx_pause_en_o,
   output reg  [4:0]  rx_pause_en_o,
   output reg         aggr_bkoff_o,
   output reg         age_tick_o,
   output reg         age_flush_all_o,
   output reg         age_fast_busy_o
);
   // Only these three low bits of the zero register live in this bank
   reg  [2:0] ctrl_zero_r;
   reg  [7:0] ctrl_one_r;
   reg  [2:0] strap_s1_r;
   reg  [2:0] strap_s2_r;
   reg        strap_done_r;
   reg  [4:0] link_s1_r;
   reg  [4:0] link_s2_r;
   reg  [4:0] link_d_r;
   reg        fast_trig_r;
   wire       tick_w;
   wire       flush_w;
   wire       busy_w;

   function pause_match;
      input [15:0] tl;
      input [47:0] da;
      begin
         pause_match = (tl == `SGCB_ETYPE_PAUSE) || (da == `SGCB_DA_PAUSE);
      end
   endfunction

   // Strap and link pins come from outside, so two flops first
   always @(posedge clk_sys_i)
   begin
      strap_s1_r <= {strap_aggr_bkoff_i, strap_age_en_i, strap_fc_dis_i};
      strap_s2_r <= strap_s1_r;
      link_s1_r  <= link_up_i;
      link_s2_r  <= link_s1_r;
   end

   // Straps load once after release; software writes win afterwards
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_zero_r  <= `SGCB_CTRL_ZERO_RST;
         ctrl_one_r   <= `SGCB_CTRL_ONE_RST;
         strap_done_r <= 1'b0;
      end
      else
      begin
         if (!strap_done_r)
         begin
            strap_done_r <= 1'b1;
            ctrl_one_r[`SGCB_C1_TX_FC_DIS]  <= strap_s2_r[0];
            ctrl_one_r[`SGCB_C1_RX_FC_DIS]  <= strap_s2_r[0];
            ctrl_one_r[`SGCB_C1_AGE_EN]     <= strap_s2_r[1];
            ctrl_one_r[`SGCB_C1_AGGR_BKOFF] <= strap_s2_r[2];
         end
         else if (reg_wr_i)
         begin
            if (reg_addr_i == `SGCB_OFS_CTRL_ZERO)
               ctrl_zero_r <= reg_wdata_i[2:0];
            if (reg_addr_i == `SGCB_OFS_CTRL_ONE)
               ctrl_one_r <= reg_wdata_i;
         end
      end
   end

   // Read port; unmapped addresses read zero
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (!reg_rd_i)
            reg_rdata_o <= 8'h00;
         else if (reg_addr_i == `SGCB_OFS_CTRL_ZERO)
            reg_rdata_o <= {5'h00, ctrl_zero_r};
         else if (reg_addr_i == `SGCB_OFS_CTRL_ONE)
            reg_rdata_o <= ctrl_one_r;
         else
            reg_rdata_o <= 8'h00;
      end
   end

   // Link-loss detect; edge logic reads only the second sync stage
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         link_d_r    <= 5'h00;
         fast_trig_r <= 1'b0;
      end
      else
      begin
         link_d_r    <= link_s2_r;
         fast_trig_r <= ctrl_zero_r[`SGCB_C0_LINK_AGE] &
                        (|(link_d_r & ~link_s2_r));
      end
   end

   sgcb_age_timer
   #(
      .NORM_CYC (NORM_AGE_CYC),
      .FAST_CYC (FAST_AGE_CYC)
   )
   u_age
   (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .age_en_i    (ctrl_one_r[`SGCB_C1_AGE_EN]),
      .fast_mode_i (ctrl_one_r[`SGCB_C1_FAST_AGE]),
      .fast_trig_i (fast_trig_r),
      .age_tick_o  (tick_w),
      .flush_all_o (flush_w),
      .fast_busy_o (busy_w)
   );

   // Frame verdict, one cycle after the descriptor
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         frm_drop_o       <= 1'b0;
         frm_drop_valid_o <= 1'b0;
      end
      else
      begin
         frm_drop_valid_o <= frm_valid_i;
         if (!frm_valid_i)
            frm_drop_o <= 1'b0;
         else if (ctrl_zero_r[`SGCB_C0_DROP_SEL])
            frm_drop_o <= pause_match(frm_type_len_i, frm_da_i);
         else if (frm_is_fc_i)
            frm_drop_o <= 1'b1;
         else if (ctrl_one_r[`SGCB_C1_PASS_ALL])
            frm_drop_o <= 1'b0;
         else if (frm_err_i)
            frm_drop_o <= 1'b1;
         else if (ctrl_one_r[`SGCB_C1_LEN_CHK] &&
                  frm_type_len_i < `SGCB_LEN_MAX &&
                  frm_type_len_i != frm_payload_len_i)
            frm_drop_o <= 1'b1;
         else
            frm_drop_o <= 1'b0;
      end
   end

   // Static controls and aging outputs to the MACs and fabric, all registered
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         buf_share_o     <= 1'b1;
         tx_pause_en_o   <= 5'h00;
         rx_pause_en_o   <= 5'h00;
         aggr_bkoff_o    <= 1'b0;
         age_tick_o      <= 1'b0;
         age_flush_all_o <= 1'b0;
         age_fast_busy_o <= 1'b0;
      end
      else
      begin
         buf_share_o   <= ctrl_zero_r[`SGCB_C0_BUF_SHARE];
         tx_pause_en_o <= ctrl_one_r[`SGCB_C1_TX_FC_DIS] ? 5'h00 :
                          an_tx_pause_i;
         rx_pause_en_o <= ctrl_one_r[`SGCB_C1_RX_FC_DIS] ? 5'h00 :
                          an_rx_pause_i;
         aggr_bkoff_o    <= ctrl_one_r[`SGCB_C1_AGGR_BKOFF];
         age_tick_o      <= tick_w;
         age_flush_all_o <= flush_w;
         age_fast_busy_o <= busy_w;
      end
   end
endmodule
`default_nettype wire
